// *** logic/dah_defs.svh ***
// Constants for the disc adapter host interface block.
`ifndef DAH_DEFS_SVH
`define DAH_DEFS_SVH
`define DAH_CLK_MHZ 200
`define DAH_NUM_DRIVES 8
`define DAH_SEEK_TMO_MS 100
`define DAH_RESTART_MIN_NS 50
`define DAH_RESTART_CYC ((`DAH_RESTART_MIN_NS * `DAH_CLK_MHZ + 999) / 1000)
`define DAH_SEEK_TMO_CYC (`DAH_SEEK_TMO_MS * 1000 * `DAH_CLK_MHZ)
`define DAH_XREG_CMD 5'h11
`define DAH_XREG_STATUS 5'h12
`define DAH_XREG_ATTN 5'h13
`define DAH_CMD_CS_LOAD 16'h00F0
`define DAH_OFF_CTRL 4'h0
`define DAH_OFF_STATUS 4'h4
`define DAH_OFF_TMO 4'h8
`define DAH_OFF_DATA 4'hC
`define DAH_CTRL_RST 3'h0
`define DAH_DATA_RST 16'h0000
`endif

// *** logic/dah_pkg.sv ***
// Types for the disc adapter host interface block.
package dah_pkg;
   typedef enum logic [1:0] {
      DAH_RS_IDLE = 2'b01,
      DAH_RS_PULSE = 2'b10
   } dah_rs_state_t;
endpackage

// *** logic/dah_top.sv ***
// Disc adapter side of the shared-resource signal interface.
//
// What this block does
// - Power-on clear resets first-seek detection logic.
// - Read data returned MSB first on bit zero.
// - Attention summary ORs drives except drive S.
// - Seek without detent for 100 ms attends.
// - After first seek, hold attention until requested.
// - Summary drops once all drive attentions clear.
// - Restart pulse, 50 ns minimum unless master clear ends it early, on error/command.
// - Restart high for four listed status errors while control store load initiate is high.
// - Maintenance mode restart forces load complete.
// - End of transfer on six status conditions.
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`include "dah_defs.svh"
module dah_top
   import dah_pkg::*;
#(
   parameter int P_SEEK_TMO_CYC = `DAH_SEEK_TMO_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Shared resources
   input wire logic i_power_on_master_clear,
   input wire logic i_master_clear,
   input wire logic i_ext_reg_write_strobe,
   input wire logic i_ext_reg_read_strobe,
   input wire logic i_proc_three_execute,
   input wire logic [4:0] i_ext_reg_num,
   input wire logic [0:15] i_ext_reg_out,
   input wire logic i_control_store_load_initiate,
   input wire logic i_maint_mode,
   output logic [0:15] o_ext_reg_input_bus,
   output logic o_drive_attention_summary,
   output logic o_load_restart_pulse,
   output logic o_end_of_transfer,
   output logic o_cs_load_complete,
   // Drives and status
   input wire logic [`DAH_NUM_DRIVES-1:0] i_drive_attn,
   input wire logic [`DAH_NUM_DRIVES-1:0] i_seek_start,
   input wire logic [`DAH_NUM_DRIVES-1:0] i_detent,
   input wire logic i_burst_check_err,
   input wire logic i_end_of_cyl,
   input wire logic i_no_sync,
   input wire logic i_seek_incomplete,
   input wire logic i_cmd_early,
   input wire logic i_missed_window,
   input wire logic i_track_boundary,
   input wire logic i_rw_term,
   input wire logic i_lost_data,
   // Avalon-MM slave
   input wire logic [3:0] i_avm_address,
   input wire logic i_avm_read,
   input wire logic i_avm_write,
   input wire logic [31:0] i_avm_writedata,
   input wire logic [3:0] i_avm_byteenable,
   output logic [31:0] o_avm_readdata,
   output logic o_avm_waitrequest
);

   localparam int ND = `DAH_NUM_DRIVES;

   function automatic logic xreg_is(input logic [4:0] num, input logic [4:0] code);
      xreg_is = (num == code);
   endfunction

   // Register state.
   logic [2:0] drive_s_reg;
   logic [15:0] data_reg;
   logic seek_seen_reg;
   logic withhold_reg;
   logic [ND-1:0] seek_run_reg;
   logic [ND-1:0] tmo_flag_reg;
   logic [24:0] tmo_cnt_reg [ND];
   dah_rs_state_t rs_state_reg;
   dah_rs_state_t rs_state_next;
   logic [3:0] rs_cnt_reg;
   logic [3:0] rs_cnt_next;
   logic rs_restart_d_reg;
   logic [3:0] rs_width_reg;

   // Decode of shared-resource accesses.
   wire xwr = i_ext_reg_write_strobe & i_proc_three_execute;
   wire xrd = i_ext_reg_read_strobe & i_proc_three_execute;
   wire req_attn_cmd = xwr & xreg_is(i_ext_reg_num, `DAH_XREG_ATTN);
   wire cs_load_cmd = xwr & xreg_is(i_ext_reg_num, `DAH_XREG_CMD) & (i_ext_reg_out == `DAH_CMD_CS_LOAD);
   wire first_seek = (|i_seek_start) & ~seek_seen_reg;

   // Status groups.
   wire err4 = i_burst_check_err | i_end_of_cyl | i_no_sync | i_seek_incomplete;
   wire eot6 = i_cmd_early | i_missed_window | i_track_boundary | i_rw_term | i_lost_data | i_no_sync;
   wire load_err = i_control_store_load_initiate & err4;
   wire rs_trig = load_err | cs_load_cmd;

   // Attention forming.
   wire [ND-1:0] drive_s_mask = ~(8'h01 << drive_s_reg);
   wire [ND-1:0] logical_attn = i_drive_attn | tmo_flag_reg;
   wire attn_any = |(logical_attn & drive_s_mask);
   wire attn_next = attn_any & ~withhold_reg;

   // Avalon decode.
   wire bus_req = i_avm_read | i_avm_write;
   wire bus_go = bus_req & ~o_avm_waitrequest;
   wire wr_ctrl = bus_go & i_avm_write & (i_avm_address == `DAH_OFF_CTRL) & i_avm_byteenable[0];
   wire wr_tmo = bus_go & i_avm_write & (i_avm_address == `DAH_OFF_TMO) & i_avm_byteenable[0];
   wire wr_data = bus_go & i_avm_write & (i_avm_address == `DAH_OFF_DATA);
   wire [ND-1:0] tmo_clr = wr_tmo ? i_avm_writedata[ND-1:0] : '0;
   wire [31:0] status_word = {16'h0000, tmo_flag_reg, 3'h0, o_cs_load_complete,
                              o_load_restart_pulse, seek_seen_reg, withhold_reg, o_drive_attention_summary};
   wire [31:0] rd_word = (i_avm_address == `DAH_OFF_CTRL) ? {29'h0, drive_s_reg} :
                         (i_avm_address == `DAH_OFF_STATUS) ? status_word :
                         (i_avm_address == `DAH_OFF_TMO) ? {24'h0, tmo_flag_reg} :
                         (i_avm_address == `DAH_OFF_DATA) ? {16'h0000, data_reg} : 32'h0000_0000;

   // Word returned on the extended-register input bus.
   wire [15:0] xstatus = {err4, eot6, i_burst_check_err, i_end_of_cyl, i_no_sync,
                          i_seek_incomplete, i_cmd_early, i_missed_window, i_track_boundary,
                          i_rw_term, i_lost_data, 5'h00};
   wire [15:0] xattn = {logical_attn, 5'h00, drive_s_reg};
   wire [15:0] eri_word = xreg_is(i_ext_reg_num, `DAH_XREG_STATUS) ? xstatus :
                          xreg_is(i_ext_reg_num, `DAH_XREG_ATTN) ? xattn : data_reg;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_avm_waitrequest <= 1'b1;
         o_avm_readdata <= 32'h0000_0000;
         drive_s_reg <= `DAH_CTRL_RST;
         data_reg <= `DAH_DATA_RST;
      end else begin
         // One wait cycle per access keeps the read mux off the bus path.
         o_avm_waitrequest <= ~(bus_req & o_avm_waitrequest);
         o_avm_readdata <= (i_avm_read & o_avm_waitrequest) ? rd_word : o_avm_readdata;
         if (wr_ctrl) begin
            drive_s_reg <= i_avm_writedata[2:0];
         end
         if (wr_data) begin
            data_reg[7:0] <= i_avm_byteenable[0] ? i_avm_writedata[7:0] : data_reg[7:0];
            data_reg[15:8] <= i_avm_byteenable[1] ? i_avm_writedata[15:8] : data_reg[15:8];
         end
      end
   end

   // First-seek detection and attention hold.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         seek_seen_reg <= 1'b0;
         withhold_reg <= 1'b0;
      end else begin
         if (i_power_on_master_clear) begin
            seek_seen_reg <= 1'b0;
            withhold_reg <= 1'b0;
         end else if (first_seek) begin
            seek_seen_reg <= 1'b1;
            withhold_reg <= 1'b1;
         end else if (req_attn_cmd) begin
            withhold_reg <= 1'b0;
         end
      end
   end

   // Seek watchdogs, one per drive.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         seek_run_reg <= '0;
         tmo_flag_reg <= '0;
         for (int i = 0; i < ND; i++) begin
            tmo_cnt_reg[i] <= 25'h0;
         end
      end else begin
         for (int i = 0; i < ND; i++) begin
            if (i_seek_start[i]) begin
               seek_run_reg[i] <= 1'b1;
               tmo_cnt_reg[i] <= 25'h0;
            end else if (i_detent[i]) begin
               seek_run_reg[i] <= 1'b0;
            end else if (seek_run_reg[i]) begin
               if (tmo_cnt_reg[i] == 25'(P_SEEK_TMO_CYC - 1)) begin
                  seek_run_reg[i] <= 1'b0;
               end
               tmo_cnt_reg[i] <= tmo_cnt_reg[i] + 25'h1;
            end
            // A timeout arriving with a software clear still sets the flag.
            if (seek_run_reg[i] & ~i_seek_start[i] & ~i_detent[i] &
                (tmo_cnt_reg[i] == 25'(P_SEEK_TMO_CYC - 1))) begin
               tmo_flag_reg[i] <= 1'b1;
            end else if (tmo_clr[i] | i_master_clear) begin
               tmo_flag_reg[i] <= 1'b0;
            end
         end
      end
   end

   // Restart pulse sequencer.
   always_comb begin
      rs_state_next = rs_state_reg;
      rs_cnt_next = rs_cnt_reg;
      case (rs_state_reg)
         DAH_RS_IDLE: begin
            if (rs_trig) begin
               rs_state_next = DAH_RS_PULSE;
               rs_cnt_next = 4'(`DAH_RESTART_CYC - 1);
            end
         end
         DAH_RS_PULSE: begin
            if (rs_cnt_reg != 4'h0) begin
               rs_cnt_next = rs_cnt_reg - 4'h1;
            end else if (!rs_trig) begin
               // A trigger arriving as the count runs out keeps the pulse up rather than losing it.
               rs_state_next = DAH_RS_IDLE;
            end
         end
         default: begin
            rs_state_next = DAH_RS_IDLE;
            rs_cnt_next = 4'h0;
         end
      endcase
      if (i_master_clear && !rs_trig) begin
         rs_state_next = DAH_RS_IDLE;
         rs_cnt_next = 4'h0;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rs_state_reg <= DAH_RS_IDLE;
         rs_cnt_reg <= 4'h0;
         rs_restart_d_reg <= 1'b0;
         o_load_restart_pulse <= 1'b0;
         o_cs_load_complete <= 1'b0;
      end else begin
         rs_state_reg <= rs_state_next;
         rs_cnt_reg <= rs_cnt_next;
         rs_restart_d_reg <= o_load_restart_pulse;
         o_load_restart_pulse <= (rs_state_next == DAH_RS_PULSE);
         if (o_load_restart_pulse & ~rs_restart_d_reg & i_maint_mode) begin
            o_cs_load_complete <= 1'b1;
         end else if (i_power_on_master_clear | i_master_clear) begin
            o_cs_load_complete <= 1'b0;
         end
      end
   end

   // Outputs toward the shared resources.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_ext_reg_input_bus <= 16'h0000;
         o_drive_attention_summary <= 1'b0;
         o_end_of_transfer <= 1'b0;
      end else begin
         // The packed range 0:15 puts the most significant bit on bit 0.
         o_ext_reg_input_bus <= xrd ? eri_word : 16'h0000;
         o_drive_attention_summary <= attn_next;
         o_end_of_transfer <= eot6;
      end
   end

   // Width gauge for the minimum-width check; it saturates so a long pulse never wraps.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rs_width_reg <= 4'h0;
      end else if (!o_load_restart_pulse) begin
         rs_width_reg <= 4'h0;
      end else if (rs_width_reg != 4'hF) begin
         rs_width_reg <= rs_width_reg + 4'h1;
      end
   end

   default clocking dah_cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   a_poweron_seek_clear: assert property (i_power_on_master_clear |=> !seek_seen_reg && !withhold_reg)
      else $error("power-on clear left first-seek logic set");
   a_eri_msb_first: assert property (xrd |=> o_ext_reg_input_bus[0] == $past(eri_word[15]))
      else $error("extended register msb not on bit 0");
   a_attn_or_drives: assert property ((logical_attn & drive_s_mask) != 0 && !withhold_reg
                                      |=> o_drive_attention_summary)
      else $error("attention summary missed a drive");
   a_drive_s_excluded: assert property (logical_attn == (8'h01 << drive_s_reg)
                                        |=> !o_drive_attention_summary)
      else $error("drive S leaked into attention");
   a_seek_timeout_attn: assert property (seek_run_reg[5] && !i_seek_start[5] && !i_detent[5] &&
                                         tmo_cnt_reg[5] == 25'(P_SEEK_TMO_CYC - 1) |=> tmo_flag_reg[5])
      else $error("seek timeout did not raise attention");
   a_first_seek_hold: assert property (first_seek && !i_power_on_master_clear
                                       |=> withhold_reg ##1 !o_drive_attention_summary)
      else $error("attention not held after first seek");
   a_attn_drop_clear: assert property (logical_attn == 8'h00 |=> !o_drive_attention_summary)
      else $error("attention stayed up with none pending");
   a_restart_width: assert property ($fell(o_load_restart_pulse) |-> rs_width_reg >= 4'(`DAH_RESTART_CYC))
      else $error("restart pulse shorter than minimum");
   a_restart_on_cmd: assert property (rs_trig |=> o_load_restart_pulse)
      else $error("restart not raised on trigger");
   a_restart_status: assert property (load_err |=> o_load_restart_pulse)
      else $error("restart low during status error");
   a_maint_complete: assert property (o_load_restart_pulse && !rs_restart_d_reg && i_maint_mode
                                      |=> o_cs_load_complete)
      else $error("maintenance restart did not force load complete");
   a_eot_status: assert property (o_end_of_transfer == $past(eot6) || $fell(i_reset_n))
      else $error("end of transfer does not follow status");

endmodule

// *** bench/dah_host_model.sv ***
// Behavioural model of the shared resources that face the adapter.
`timescale 1ns/1ps
module dah_host_model (
   // Clock and control
   input wire logic i_clk,
   input wire logic i_power_on_master_clear,
   input wire logic i_load_restart_pulse,
   input wire logic [0:15] i_ext_reg_input_bus,
   input wire logic i_maint_mode,
   input wire logic i_burst_check_err,
   input wire logic i_drive_attention_summary,
   input wire logic i_end_of_transfer,
   // Extended register strobes
   output logic o_wr,
   output logic o_rd,
   output logic o_exec,
   output logic [4:0] o_num,
   output logic [0:15] o_word,
   output logic o_init
);
   logic por_q;
   logic rs_q;
   logic slice_req;
   logic term_q;
   initial begin
      rs_q = 1'b0;
      slice_req = 1'b0;
      term_q = 1'b0;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_exec = 1'b0;
      o_num = 5'h10;
      o_word = 16'h0000;
      o_init = 1'b0;
      por_q = 1'b0;
   end
   always @(posedge i_clk) begin
      por_q <= i_power_on_master_clear;
      rs_q <= i_load_restart_pulse;
      term_q <= i_end_of_transfer;
      // The execute flag stands in for the processor active flag here.
      if (i_drive_attention_summary && !o_exec) begin
         slice_req <= 1'b1;
      end else if (o_exec) begin
         slice_req <= 1'b0;
      end
      if (por_q && !i_power_on_master_clear) begin
         o_init <= 1'b1;
      end else if (rs_q && !i_load_restart_pulse && !(i_maint_mode && i_burst_check_err)) begin
         o_init <= 1'b1;
      end else if (i_load_restart_pulse || i_power_on_master_clear) begin
         o_init <= 1'b0;
      end
   end
   // One store or load slice; the answer is taken at the edge after the strobe, and the word is
   // inverted once released so stale data never looks valid.
   task automatic xfer(input logic wr, input logic [4:0] num, input logic [0:15] w, output logic [0:15] r);
      @(posedge i_clk);
      o_num <= num;
      o_word <= w;
      o_wr <= wr;
      o_rd <= !wr;
      o_exec <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      o_exec <= 1'b0;
      o_word <= ~w;
      @(posedge i_clk);
      r = i_ext_reg_input_bus;
   endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking testbench for the disc adapter host interface block.
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, rst_n = 1'b0, por = 1'b0, mc = 1'b0, maint = 1'b0;
   logic [7:0] attn = 8'h00, seek = 8'h00, det = 8'h00;
   logic [8:0] st = 9'h000;
   logic [3:0] a_addr = 4'h0;
   logic a_rd = 1'b0, a_wr = 1'b0;
   logic [31:0] a_wdata = 32'h0, rdata, rv;
   logic wreq, wr, rd, ex, init, summ, pulse, eot, csdone;
   logic [4:0] num;
   logic [0:15] word, bus, r;
   int miscompares = 0, samples_checked = 0, cycles = 0, pw = 0, pw_last = 0;
   dah_host_model u_host (.i_clk(clk), .i_power_on_master_clear(por), .i_load_restart_pulse(pulse),
      .i_ext_reg_input_bus(bus), .i_maint_mode(maint), .i_burst_check_err(st[8]),
      .i_drive_attention_summary(summ), .i_end_of_transfer(eot), .o_wr(wr), .o_rd(rd), .o_exec(ex),
      .o_num(num), .o_word(word), .o_init(init));
   dah_top #(.P_SEEK_TMO_CYC(50)) u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_power_on_master_clear(por),
      .i_master_clear(mc), .i_ext_reg_write_strobe(wr), .i_ext_reg_read_strobe(rd), .i_proc_three_execute(ex),
      .i_ext_reg_num(num), .i_ext_reg_out(word), .i_control_store_load_initiate(init), .i_maint_mode(maint),
      .o_ext_reg_input_bus(bus), .o_drive_attention_summary(summ), .o_load_restart_pulse(pulse),
      .o_end_of_transfer(eot), .o_cs_load_complete(csdone), .i_drive_attn(attn), .i_seek_start(seek),
      .i_detent(det), .i_burst_check_err(st[8]), .i_end_of_cyl(st[7]), .i_no_sync(st[5]),
      .i_seek_incomplete(st[6]), .i_cmd_early(st[4]), .i_missed_window(st[3]), .i_track_boundary(st[2]),
      .i_rw_term(st[1]), .i_lost_data(st[0]), .i_avm_address(a_addr), .i_avm_read(a_rd),
      .i_avm_write(a_wr), .i_avm_writedata(a_wdata), .i_avm_byteenable(4'hF), .o_avm_readdata(rdata),
      .o_avm_waitrequest(wreq));
   initial begin
      // The five host phases all fall on this one clock, so the block sees a single edge.
      forever #2.5 clk = ~clk;
   end
   task automatic complete_run();
      $display("samples_checked=%0d miscompares=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // The ceiling is more than forty times the expected run so a stalled handshake ends the run.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end
   // Length of the last restart pulse, in clock cycles.
   always @(posedge clk) begin
      if (pulse === 1'b1) begin
         pw <= pw + 1;
      end else if (pw != 0) begin
         pw_last <= pw;
         pw <= 0;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tk(input int k);
      repeat (k) @(posedge clk);
   endtask
   // The request stands until the edge at which waitrequest is seen low; read data is taken there.
   task automatic avm(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      a_addr <= a;
      a_wdata <= d;
      a_rd <= !w;
      a_wr <= w;
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      q = rdata;
      a_rd <= 1'b0;
      a_wr <= 1'b0;
   endtask
   task automatic t_regs();
      avm(0, 4'h0, 0, rv);
      chk(rv, 32'h0);
      avm(1, 4'hC, 32'h0000_8001, rv);
      avm(0, 4'hC, 0, rv);
      chk(rv, 32'h0000_8001);
      avm(0, 4'h2, 0, rv);
      chk(rv, 32'h0);
      u_host.xfer(0, 5'h14, 16'h0000, r);
      chk(r, 16'h8001);
      chk(r[0], 1'b1);
      $display("test regs done");
   endtask
   task automatic t_attn();
      avm(1, 4'h0, 32'h3, rv);
      attn <= 8'h08;
      tk(3);
      #1 chk(summ, 1'b0);
      attn <= 8'h48;
      tk(3);
      #1 chk(summ, 1'b1);
      chk(u_host.slice_req, 1'b1);
      attn <= 8'h08;
      tk(3);
      #1 chk(summ, 1'b0);
      tk(1);
      attn <= 8'h00;
      por <= 1'b1;
      tk(2);
      por <= 1'b0;
      tk(2);
      seek <= 8'h04;
      tk(1);
      seek <= 8'h00;
      det <= 8'h04;
      attn <= 8'h04;
      tk(4);
      #1 chk(summ, 1'b0);
      u_host.xfer(1, 5'h13, 16'h0000, r);
      tk(3);
      #1 chk(summ, 1'b1);
      tk(1);
      attn <= 8'h00;
      tk(3);
      #1 chk(summ, 1'b0);
      $display("test attention done");
   endtask
   task automatic t_tmo();
      tk(1);
      seek <= 8'h20;
      tk(1);
      seek <= 8'h00;
      tk(20);
      #1 chk(summ, 1'b0);
      tk(40);
      #1 chk(summ, 1'b1);
      avm(1, 4'h8, 32'hFFFF_FFFF, rv);
      tk(3);
      #1 chk(summ, 1'b0);
      tk(1);
      seek <= 8'h40;
      tk(1);
      seek <= 8'h00;
      tk(5);
      det <= 8'h40;
      tk(70);
      #1 chk(summ, 1'b0);
      tk(1);
      seek <= 8'h20;
      tk(1);
      seek <= 8'h00;
      tk(60);
      #1 chk(summ, 1'b1);
      mc <= 1'b1;
      tk(1);
      mc <= 1'b0;
      tk(3);
      #1 chk(summ, 1'b0);
      $display("test seek timeout done");
   endtask
   task automatic t_restart();
      maint <= 1'b1;
      u_host.xfer(1, 5'h11, 16'h00F0, r);
      tk(14);
      chk(pw_last, 32'h0000_000A);
      chk(csdone, 1'b1);
      tk(1);
      maint <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         tk(1);
         st <= (i == 5) ? 9'h020 : (9'h001 << i);
         tk(2);
         #1 chk(eot, 1'b1);
         chk(u_host.term_q, 1'b1);
         tk(1);
         st <= 9'h000;
         tk(2);
         #1 chk(eot, 1'b0);
         chk(u_host.term_q, 1'b0);
      end
      for (int i = 5; i < 9; i++) begin
         tk(1);
         por <= 1'b1;
         tk(2);
         por <= 1'b0;
         tk(3);
         st <= 9'h001 << i;
         tk(3);
         #1 chk(pulse, 1'b1);
         tk(1);
         st <= 9'h000;
         tk(20);
      end
      $display("test restart done");
   endtask
   initial begin
      tk(20);
      rst_n <= 1'b1;
      t_regs();
      t_attn();
      t_tmo();
      t_restart();
      complete_run();
   end
endmodule
